// >>> bocw_pkg.sv
// package: register map, field layout and timing for the buck over-current block
package bocw_pkg;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [7:0] BOCW_ADDR_BYPASS = 8'h70;
  localparam logic [7:0] BOCW_ADDR_LIMIT = 8'hA0;
  localparam logic [7:0] BOCW_ADDR_FLAGS = 8'hAE;

  // ****************************************************************
  // reset values and field masks
  // ****************************************************************
  localparam logic [7:0] BOCW_LIMIT_RESET = 8'h67;
  localparam logic [7:0] BOCW_FLAGS_RESET = 8'h00;
  localparam logic [7:0] BOCW_FLAGS_MASK = 8'h67;
  localparam logic [7:0] BOCW_BYPASS_MASK = 8'h02;
  localparam logic [4:0] BOCW_LIMIT_LOW_PATTERN = 5'h07;

  // field positions
  localparam int BOCW_BIT_HOLDOFF = 7;
  localparam int BOCW_BIT_R6 = 6;
  localparam int BOCW_BIT_R5 = 5;
  localparam int BOCW_BIT_GROUP = 1;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int BOCW_CLK_MHZ = 200;
  localparam int BOCW_HOLD_SHORT_US = 10;
  localparam int BOCW_HOLD_LONG_US = 100;
  localparam int BOCW_HOLD_SHORT_CYC = BOCW_HOLD_SHORT_US * BOCW_CLK_MHZ;
  localparam int BOCW_HOLD_LONG_CYC = BOCW_HOLD_LONG_US * BOCW_CLK_MHZ;

  // ****************************************************************
  // carrier types
  // ****************************************************************
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bocw_req_t;

  // per rail signals, index order: rail 0, 1, 2, 5, 6
  typedef struct packed {
    logic [4:0] warn;
    logic [2:0] in_transition;
  } bocw_sense_t;

endpackage : bocw_pkg

// >>> bocw_holdoff.sv
// hold-off timer for one rail among rails 0 to 2
`timescale 1ns/1ps
`default_nettype none
module bocw_holdoff
  import bocw_pkg::*;
#(
  parameter int SHORT_CYC = BOCW_HOLD_SHORT_CYC,
  parameter int LONG_CYC = BOCW_HOLD_LONG_CYC
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic enable,
  input wire logic long_sel,
  input wire logic warn,
  input wire logic in_transition,
  output logic limit
);

  localparam int CW = $clog2(LONG_CYC + 1);

  typedef struct packed {
    logic [CW-1:0] count;
    logic limit;
  } bocw_hold_state_t;

  bocw_hold_state_t st_q;
  bocw_hold_state_t st_d;
  logic [CW-1:0] target;

  initial
  begin
    if (SHORT_CYC < 1 || LONG_CYC < SHORT_CYC)
      $error("bocw_holdoff: bad hold-off counts");
  end

  always_comb
  begin
    st_d = st_q;
    target = long_sel ? CW'(LONG_CYC) : CW'(SHORT_CYC);
    if (!enable || !warn)
    begin
      st_d.count = '0;
      st_d.limit = 1'b0;
    end
    else if (!in_transition)
      st_d.limit = 1'b1;
    else if (st_q.count >= target)
      st_d.limit = 1'b1;
    else
      st_d.count = st_q.count + CW'(1);
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign limit = st_q.limit;

endmodule : bocw_holdoff
`default_nettype wire

// >>> bocw_top.sv
// register bank and first-level limit control for the buck over-current block
`timescale 1ns/1ps
`default_nettype none
module bocw_top
  import bocw_pkg::*;
#(
  parameter int SHORT_CYC = BOCW_HOLD_SHORT_CYC,
  parameter int LONG_CYC = BOCW_HOLD_LONG_CYC
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire bocw_req_t req,
  input wire bocw_sense_t sense,
  input wire logic [2:0] rail012_limit_enable,
  input wire logic otp_valid,
  input wire logic [7:0] otp_bypass,
  output logic [7:0] rdata,
  output logic [2:0] rail012_limit,
  output logic rail5_first_level,
  output logic rail6_first_level
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] limit_ctl;
    logic [7:0] bypass;
    logic otp_done;
    logic [7:0] rdata;
    logic r5;
    logic r6;
  } bocw_state_t;

  bocw_state_t st_q;
  bocw_state_t st_d;
  logic [7:0] warn_bits;
  logic [2:0] hold_limit;

  initial
  begin
    if (SHORT_CYC < 1 || LONG_CYC < SHORT_CYC)
      $error("bocw_top: bad hold-off counts");
  end

  // map rail index order onto flag bit positions
  function automatic logic [7:0] rail_to_bits(input logic [4:0] r);
    rail_to_bits = {1'b0, r[4], r[3], 2'b00, r[2], r[1], r[0]};
  endfunction : rail_to_bits

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction : hit

  assign warn_bits = rail_to_bits(sense.warn);

  // ****************************************************************
  // hold-off timers for rails 0 to 2
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_hold
      bocw_holdoff #(
        .SHORT_CYC(SHORT_CYC),
        .LONG_CYC(LONG_CYC)
      ) u_hold (
        .clk(clk),
        .resetn(resetn),
        .enable(rail012_limit_enable[g]),
        .long_sel(st_q.limit_ctl[BOCW_BIT_HOLDOFF]),
        .warn(sense.warn[g]),
        .in_transition(sense.in_transition[g]),
        .limit(hold_limit[g])
      );
    end
  endgenerate

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    st_d = st_q;
    // one-shot load of group bypass after reset
    if (!st_q.otp_done && otp_valid)
    begin
      st_d.bypass = otp_bypass & BOCW_BYPASS_MASK;
      st_d.otp_done = 1'b1;
    end
    if (req.wr && hit(req.addr, BOCW_ADDR_BYPASS))
      st_d.bypass = req.wdata & BOCW_BYPASS_MASK;
    if (req.wr && hit(req.addr, BOCW_ADDR_LIMIT))
      st_d.limit_ctl = {req.wdata[7:5], BOCW_LIMIT_LOW_PATTERN};
    st_d.flags = st_q.flags;
    if (req.wr && hit(req.addr, BOCW_ADDR_FLAGS))
      st_d.flags = st_q.flags & ~req.wdata;
    st_d.flags = (st_d.flags | warn_bits) & BOCW_FLAGS_MASK;
    // read data
    st_d.rdata = st_q.rdata;
    if (req.rd)
    begin
      if (hit(req.addr, BOCW_ADDR_BYPASS))
        st_d.rdata = st_q.bypass;
      else if (hit(req.addr, BOCW_ADDR_LIMIT))
        st_d.rdata = st_q.limit_ctl;
      else if (hit(req.addr, BOCW_ADDR_FLAGS))
        st_d.rdata = st_q.flags;
      else
        st_d.rdata = 8'h00;
    end
    // first-level limit enables for rails 5 and 6
    st_d.r5 = st_q.limit_ctl[BOCW_BIT_R5] &
      ~st_q.bypass[BOCW_BIT_GROUP];
    st_d.r6 = st_q.limit_ctl[BOCW_BIT_R6] &
      ~st_q.bypass[BOCW_BIT_GROUP];
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_q <= '0;
      st_q.flags <= BOCW_FLAGS_RESET;
      st_q.limit_ctl <= BOCW_LIMIT_RESET;
    end
    else
      st_q <= st_d;
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign rdata = st_q.rdata;
  assign rail012_limit = hold_limit;
  assign rail5_first_level = st_q.r5;
  assign rail6_first_level = st_q.r6;

endmodule : bocw_top
`default_nettype wire

// >>> bocw_monitor.sv
// checker: port assertions for the over-current register block
`timescale 1ns/1ps
`default_nettype none
module bocw_monitor
  import bocw_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire bocw_req_t req,
  input wire bocw_sense_t sense,
  input wire logic [2:0] rail012_limit_enable,
  input wire logic [7:0] rdata,
  input wire logic [2:0] rail012_limit,
  input wire logic rail5_first_level,
  input wire logic rail6_first_level
);
  // ****
  // properties
  // ****
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  wire logic rf = req.rd && req.addr == BOCW_ADDR_FLAGS;
  wire logic wf = req.wr && req.addr == BOCW_ADDR_FLAGS;
  wire logic wb = req.wr && req.addr == BOCW_ADDR_BYPASS;
  wire logic wl = req.wr && req.addr == BOCW_ADDR_LIMIT;
  AST_SET: assert property (sense.warn[3] ##1 rf |=> rdata[5])
    else $error("flag not set");
  AST_CLR: assert property (wf && req.wdata[0] && !sense.warn[0]
    ##1 !sense.warn[0] ##1 rf |=> !rdata[0]) else $error("no clear");
  AST_KEEP: assert property (wf && req.wdata[0] && sense.warn[0]
    ##1 !wf ##1 rf |=> rdata[0]) else $error("set lost");
  AST_RSV: assert property (rf |=> !rdata[7] && !rdata[4] && !rdata[3])
    else $error("reserved set");
  AST_PAT: assert property (req.rd && req.addr == BOCW_ADDR_LIMIT
    |=> rdata[4:0] == BOCW_LIMIT_LOW_PATTERN) else $error("low bits");
  AST_BYP: assert property (wb && req.wdata[1]
    |-> ##2 !rail5_first_level && !rail6_first_level) else $error("bypass");
  AST_SEL: assert property (wl && !req.wdata[6]
    |-> ##2 !rail6_first_level) else $error("second level");
  AST_EN: assert property (!rail012_limit_enable[1]
    |=> !rail012_limit[1]) else $error("limit without enable");
  AST_WRN: assert property (!sense.warn[2] |=> !rail012_limit[2])
    else $error("limit without warning");
  cover property (rail012_limit[0]);
  cover property (wf && req.wdata[0] && sense.warn[0]);
  cover property ($fell(rail5_first_level));
endmodule : bocw_monitor
bind bocw_top bocw_monitor mon (.*);
`default_nettype wire

// >>> bocw_host_model.sv
// host model: register reads and writes on the request port
`timescale 1ns/1ps
`default_nettype none
module bocw_host_model
  import bocw_pkg::*;
(
  input wire logic clk,
  input wire logic [7:0] rdata,
  output var bocw_req_t req
);
  initial req = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == BOCW_ADDR_LIMIT) v[4:0] = BOCW_LIMIT_LOW_PATTERN;
    if (a == BOCW_ADDR_BYPASS) v = v & BOCW_BYPASS_MASK;
    req <= '{wr: 1'h1, rd: 1'h0, addr: a, wdata: v};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    req <= '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 8'h00};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
    d = rdata;
  endtask : rd
endmodule : bocw_host_model
`default_nettype wire

// >>> testbench.sv
// testbench: register, flag and limit scenarios for the over-current block
`timescale 1ns/1ps
`default_nettype none
module testbench
  import bocw_pkg::*;
;
  localparam int SHORT = 4;
  localparam int LONG = 12;
  logic clk = 1'h0;
  logic resetn = 1'h0;
  bocw_req_t req;
  bocw_sense_t sense = '0;
  logic [2:0] rail012_limit_enable = '0;
  logic otp_valid = 1'h1;
  logic [7:0] otp_bypass = 8'h03;
  logic [7:0] rdata;
  logic [2:0] rail012_limit;
  logic rail5_first_level;
  logic rail6_first_level;
  int err_total = 0;
  int checks = 0;
  always #2.5 clk = ~clk;
  bocw_top #(.SHORT_CYC(SHORT), .LONG_CYC(LONG)) uut (.*);
  bocw_host_model host (.clk, .rdata, .req);
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    chk("register", e, d);
  endtask : rchk
  task automatic t_reset;
    rchk(BOCW_ADDR_BYPASS, 8'h02);
    rchk(BOCW_ADDR_LIMIT, BOCW_LIMIT_RESET);
    rchk(BOCW_ADDR_FLAGS, BOCW_FLAGS_RESET);
    host.wr(BOCW_ADDR_BYPASS, 8'h00);
    @(posedge clk);
    chk("first level", 8'h03, {6'h00, rail6_first_level, rail5_first_level});
    $display("t_reset end");
  endtask : t_reset
  task automatic t_flags;
    sense.warn <= 5'h1F;
    @(posedge clk);
    sense.warn <= 5'h00;
    rchk(BOCW_ADDR_FLAGS, BOCW_FLAGS_MASK);
    host.wr(BOCW_ADDR_FLAGS, 8'h00);
    rchk(BOCW_ADDR_FLAGS, BOCW_FLAGS_MASK);
    host.wr(BOCW_ADDR_FLAGS, 8'h21);
    rchk(BOCW_ADDR_FLAGS, 8'h46);
    sense.warn[0] <= 1'h1;
    fork
      host.wr(BOCW_ADDR_FLAGS, 8'hFF);
      @(posedge clk) sense.warn[0] <= 1'h0;
    join
    rchk(BOCW_ADDR_FLAGS, 8'h01);
    $display("t_flags end");
  endtask : t_flags
  task automatic t_first;
    for (int i = 0; i < 8; i++)
    begin
      host.wr(BOCW_ADDR_LIMIT, {1'h0, i[1:0], 5'h07});
      host.wr(BOCW_ADDR_BYPASS, {6'h00, i[2], 1'h0});
      @(posedge clk);
      chk("first level", {6'h00, i[1:0] & {2{!i[2]}}},
          {6'h00, rail6_first_level, rail5_first_level});
    end
    $display("t_first end");
  endtask : t_first
  task automatic t_hold(input logic sel, input int n);
    int c;
    host.wr(BOCW_ADDR_LIMIT, {sel, 2'h3, 5'h07});
    rail012_limit_enable <= 3'h5;
    sense <= '{warn: 5'h07, in_transition: 3'h7};
    c = 0;
    while (rail012_limit[0] !== 1'h1 && c < 50)
    begin
      @(posedge clk);
      c++;
    end
    chk("holdoff", 8'h01, {7'h00, c >= n && c <= n + 3});
    repeat (2) @(posedge clk);
    chk("limits", 8'h05, {5'h00, rail012_limit});
    sense <= '0;
    repeat (2) @(posedge clk);
    chk("limits", 8'h00, {5'h00, rail012_limit});
    $display("t_hold end");
  endtask : t_hold
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  initial
  begin
    #50us;
    err_total++;
    $display("[FAIL] watchdog expected done seen hang");
    stop_test();
  end
  initial
  begin
    repeat (16) @(posedge clk);
    resetn <= 1'h1;
    @(posedge clk);
    t_reset();
    t_flags();
    t_first();
    t_hold(1'h0, SHORT);
    t_hold(1'h1, LONG);
    stop_test();
  end
endmodule : testbench
`default_nettype wire
